// ==== design/smws_top.sv ====
// Purpose : Software stop mode entry, wake and clock output control
// Assumes : Core, oscillator and pads obey the enables driven here
// Notes   : Wake by reset is the ordinary synchronous reset
//
// Operation
// - In stop, CPU clock, system clock and clock generator are all halted.
// - Writing the stop request bit through the control port enters stop.
// - Stop keeps register and RAM contents, halts peripherals and execution.
// - Stop floats expansion bus, holds ports, drives clock output pin low.
// - Only an interrupt edge or the reset input ends stop.
// - Interrupt wake also accepts it, unless entered inside its handler: then pending.
// - Reset wake performs the ordinary reset sequence.
// - Valid edge ends stop; counter starts at following inactive edge.
// - After count completes, clocks restart and handler is entered.
// - Stop requested while interrupt pending wakes at once, counting if resonator.
// - Reset falling edge ends stop; outside sets settling time by pulse width.
// - External clock select 1: no counting, execution restarts immediately.
// - Resonator select 0: counter runs, execution restarts when done.
// - Counter clock select 0 gives fxx over 2^8, 1 gives 2^9.
// - Inhibit mode stops the clock output pin, held low.
// - Mode field 00 normal, 11 inhibit, others reserved.
// - Single-chip: clock output low after reset until 00 written.
// - Flash programming mode: clock output pin always low.
`timescale 1ns/10ps
`default_nettype none
module smws_top
    import smws_pkg::*;
#(
    parameter int unsigned STAB_CYC_DIV256 = STAB_CYC_SEL0,
    parameter int unsigned STAB_CYC_DIV512 = STAB_CYC_SEL1
) (
    input  wire logic       sys_clk_in,
    input  wire logic       nrst_in,
    input  wire logic       psc_wr_in,
    input  wire logic [7:0] psc_wdata_in,
    input  wire logic       nmi_pin_in,
    input  wire logic       nmi_rise_sel_in,
    input  wire logic       nmi_ack_in,
    input  wire logic       nmi_pending_flag_in,
    input  wire logic       single_chip_in,
    input  wire logic       flash_prog_in,
    output var  logic [7:0] psc_rdata_out,
    output var  logic       cpu_clk_en_out,
    output var  logic       sys_clk_en_out,
    output var  logic       clkgen_en_out,
    output var  logic       periph_stop_out,
    output var  logic       bus_float_out,
    output var  logic       port_hold_out,
    output var  logic       stop_mode_out,
    output var  logic       stab_busy_out,
    output var  logic       nmi_req_out,
    output var  logic       nmi_take_out,
    output var  logic       clock_output_pin_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    smws_state_e       state_reg;
    smws_state_e       state_next;
    logic [1:0]        clock_output_pin_mode_reg;
    logic              stab_clock_select_bit;
    logic              clock_source_select_bit;
    logic              stop_request_bit;
    logic              clock_output_pin_released_reg;
    logic [2:0]        pin_sync;
    logic              nmi_lvl;
    logic              single_chip;
    logic              flash_prog;
    logic              nmi_prev_reg;
    logic [1:0]        arm_cnt_reg;
    logic              nmi_active;
    logic              nmi_edge;
    logic              nmi_req_reg;
    logic [STAB_W-1:0] stabilization_counter;
    logic [STAB_W-1:0] stab_last;
    logic              stab_done;
    logic              stop_wr;
    logic              resume;
    logic              clk_allow;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    smws_sync #(
        .W          (3)
    ) u_pin_sync (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .d_in       ({flash_prog_in, single_chip_in, nmi_pin_in}),
        .q_out      (pin_sync)
    );

    assign nmi_lvl     = pin_sync[0];
    assign single_chip = pin_sync[1];
    assign flash_prog  = pin_sync[2];

    // ------------------------------------------------------------
    // Interrupt edge detection and request latch
    // ------------------------------------------------------------
    // Edges ignored until synchroniser has settled after reset
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            nmi_prev_reg <= 1'b0;
            arm_cnt_reg  <= 2'h0;
        end else begin
            nmi_prev_reg <= nmi_lvl;
            if (arm_cnt_reg != ARM_DONE) begin
                arm_cnt_reg <= arm_cnt_reg + 2'h1;
            end
        end
    end

    // Active level is the level following the valid edge
    assign nmi_active = (nmi_lvl == nmi_rise_sel_in);
    assign nmi_edge   = (arm_cnt_reg == ARM_DONE) && nmi_active
                        && (nmi_prev_reg != nmi_lvl);

    // A new edge in the acknowledge cycle is kept, set beats clear
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            nmi_req_reg <= 1'b0;
        end else if (nmi_edge) begin
            nmi_req_reg <= 1'b1;
        end else if (nmi_ack_in) begin
            nmi_req_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    assign stop_wr = psc_wr_in && (state_reg == ST_RUN)
                     && psc_wdata_in[STOP_BIT];

    // Writes only land while the core runs; core is frozen otherwise
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            clock_output_pin_mode_reg         <= PSC_RESET[MODE_HI_BIT:MODE_LO_BIT];
            stab_clock_select_bit   <= PSC_RESET[STAB_CLOCK_SELECT_BIT_BIT];
            clock_source_select_bit <= PSC_RESET[CLOCK_SOURCE_SELECT_BIT_BIT];
        end else if (psc_wr_in && (state_reg == ST_RUN)) begin
            clock_output_pin_mode_reg         <= psc_wdata_in[MODE_HI_BIT:MODE_LO_BIT];
            stab_clock_select_bit   <= psc_wdata_in[STAB_CLOCK_SELECT_BIT_BIT];
            clock_source_select_bit <= psc_wdata_in[CLOCK_SOURCE_SELECT_BIT_BIT];
        end
    end

    // Stop bit reads back as one until the wake clears it
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            stop_request_bit <= 1'b0;
        end else begin
            stop_request_bit <= (state_next != ST_RUN);
        end
    end

    // Clock output stays low after reset until 00 is written
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            clock_output_pin_released_reg <= 1'b0;
        end else if (psc_wr_in && (state_reg == ST_RUN)
                     && (psc_wdata_in[MODE_HI_BIT:MODE_LO_BIT] == CLOCK_OUTPUT_PIN_NORMAL)) begin
            clock_output_pin_released_reg <= 1'b1;
        end
    end

    // Read image, unused bits as zero
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            psc_rdata_out <= PSC_RESET;
        end else begin
            psc_rdata_out <= {clock_output_pin_mode_reg, stab_clock_select_bit,
                              clock_source_select_bit, 2'h0,
                              (state_next != ST_RUN), 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Stabilization counter
    // ------------------------------------------------------------
    // Counts raw oscillator cycles; the prescaler is folded in
    assign stab_last = stab_clock_select_bit ?
                       STAB_W'(STAB_CYC_DIV512 - 1) :
                       STAB_W'(STAB_CYC_DIV256 - 1);
    assign stab_done = (state_reg == ST_STAB) && (stabilization_counter == stab_last);

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            stabilization_counter <= '0;
        end else if (state_reg == ST_STAB) begin
            stabilization_counter <= stabilization_counter + STAB_W'(1);
        end else begin
            stabilization_counter <= '0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Reset is the only other way out, handled by nrst_in itself
    always_comb begin
        state_next = state_reg;
        resume     = 1'b0;
        case (state_reg)
            ST_RUN: begin
                if (stop_wr && (nmi_req_reg || nmi_edge)) begin
                    // Pending request: wake at once; the same write may change the source
                    if (psc_wdata_in[CLOCK_SOURCE_SELECT_BIT_BIT]) begin
                        resume = 1'b1;
                    end else begin
                        state_next = ST_STAB;
                    end
                end else if (stop_wr) begin
                    state_next = ST_STOP;
                end
            end
            ST_STOP: begin
                if (nmi_edge && clock_source_select_bit) begin
                    state_next = ST_RUN;
                    resume     = 1'b1;
                end else if (nmi_edge) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!nmi_active) begin
                    state_next = ST_STAB;
                end
            end
            ST_STAB: begin
                if (stab_done) begin
                    state_next = ST_RUN;
                    resume     = 1'b1;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    // Synchronous reset returns to run from any state
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            state_reg <= ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Clock and pad enables
    // ------------------------------------------------------------
    // Registered from next state so they line up with state_reg
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            cpu_clk_en_out  <= 1'b1;
            sys_clk_en_out  <= 1'b1;
            clkgen_en_out   <= 1'b1;
            periph_stop_out <= 1'b0;
            bus_float_out   <= 1'b0;
            port_hold_out   <= 1'b0;
            stop_mode_out   <= 1'b0;
            stab_busy_out   <= 1'b0;
        end else begin
            cpu_clk_en_out  <= (state_next == ST_RUN);
            sys_clk_en_out  <= (state_next == ST_RUN);
            clkgen_en_out   <= (state_next != ST_STOP);
            periph_stop_out <= (state_next != ST_RUN);
            bus_float_out   <= (state_next != ST_RUN);
            port_hold_out   <= (state_next != ST_RUN);
            stop_mode_out   <= (state_next != ST_RUN);
            stab_busy_out   <= (state_next == ST_STAB);
        end
    end

    // ------------------------------------------------------------
    // Interrupt hand-off to the core
    // ------------------------------------------------------------
    // Inside the handler the wake only restarts; request stays pending
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            nmi_req_out  <= 1'b0;
            nmi_take_out <= 1'b0;
        end else begin
            nmi_req_out  <= (nmi_req_reg || nmi_edge) && !(nmi_ack_in && !nmi_edge);
            nmi_take_out <= resume && !nmi_pending_flag_in;
        end
    end

    // ------------------------------------------------------------
    // Clock output pin
    // ------------------------------------------------------------
    // Half rate of sys_clk_in; reserved codes also keep the pin low
    assign clk_allow = (clock_output_pin_mode_reg == CLOCK_OUTPUT_PIN_NORMAL)
                       && !flash_prog
                       && (!single_chip || clock_output_pin_released_reg)
                       && (state_next == ST_RUN);

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            clock_output_pin_out <= 1'b0;
        end else begin
            clock_output_pin_out <= clk_allow && !clock_output_pin_out;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    a_stop_clocks: assert property (
        (state_reg == ST_STOP) |-> (!cpu_clk_en_out && !sys_clk_en_out && !clkgen_en_out))
        else $error("clocks running in stop");
    a_stop_entry: assert property (
        (stop_wr && !nmi_req_reg && !nmi_edge) |=> (state_reg == ST_STOP) && stop_mode_out)
        else $error("stop not entered");
    a_stop_pads: assert property (
        stop_mode_out |-> (bus_float_out && port_hold_out && periph_stop_out
                          && !clock_output_pin_out && stop_request_bit))
        else $error("pads not parked in stop");
    a_wake_source: assert property (
        ((state_reg == ST_STOP) && !nmi_edge) |=> (state_reg == ST_STOP))
        else $error("stop left without wake source");
    a_take_pulse: assert property (
        (stab_done && !nmi_pending_flag_in) |=> nmi_take_out ##1 !nmi_take_out)
        else $error("handler entry pulse missing");
    a_wait_inact: assert property (
        ((state_reg == ST_WAIT) && nmi_active) |=> (state_reg == ST_WAIT) && !stab_busy_out)
        else $error("count began before inactive edge");
    a_stab_done: assert property (
        stab_done |=> (cpu_clk_en_out && (state_reg == ST_RUN)))
        else $error("no restart after count");
    a_stab_hold: assert property (
        ((state_reg == ST_STAB) && !stab_done) |=> (state_reg == ST_STAB) && !cpu_clk_en_out)
        else $error("restart before count complete");
    a_ext_clk: assert property (
        ((state_reg == ST_STOP) && nmi_edge && clock_source_select_bit)
        |=> cpu_clk_en_out && !stab_busy_out)
        else $error("external clock wake delayed");
    a_clock_output_pin_low: assert property (
        ((clock_output_pin_mode_reg != CLOCK_OUTPUT_PIN_NORMAL) || flash_prog) |=> !clock_output_pin_out)
        else $error("clock output not held low");
    a_strap_low: assert property (
        (single_chip && !clock_output_pin_released_reg) |=> !clock_output_pin_out)
        else $error("clock output before release");

    c_stop_wait: cover property ((state_reg == ST_STOP) ##1 (state_reg == ST_WAIT));
    c_stab_end: cover property (stab_done ##1 nmi_take_out);
    c_fast_wake: cover property (stop_wr && nmi_req_reg);
    c_clock_output_pin_run: cover property (clock_output_pin_out ##1 !clock_output_pin_out);

endmodule // smws_top
`default_nettype wire

// ==== design/smws_pkg.sv ====
// Purpose : Shared constants for the stop mode wake sequencer
// Assumes : sys_clk_in is the oscillator clock fxx
// Notes   : Control register image is eight bits wide
package smws_pkg;

    // ------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------
    localparam int          MODE_HI_BIT   = 7;
    localparam int          MODE_LO_BIT   = 6;
    localparam int          STAB_CLOCK_SELECT_BIT_BIT      = 5;
    localparam int          CLOCK_SOURCE_SELECT_BIT_BIT     = 4;
    localparam int          STOP_BIT      = 1;
    localparam logic [7:0]  PSC_RESET     = 8'hc0;
    localparam logic [1:0]  CLOCK_OUTPUT_PIN_NORMAL = 2'h0;
    localparam logic [1:0]  CLOCK_OUTPUT_PIN_INHIB  = 2'h3;

    // ------------------------------------------------------------
    // Stabilization counter timing (oscillator cycles)
    // ------------------------------------------------------------
    localparam int unsigned STAB_TICKS    = 256;
    localparam int unsigned STAB_DIV_LOG0 = 8;
    localparam int unsigned STAB_DIV_LOG1 = 9;
    localparam int unsigned STAB_CYC_SEL0 = STAB_TICKS << STAB_DIV_LOG0;
    localparam int unsigned STAB_CYC_SEL1 = STAB_TICKS << STAB_DIV_LOG1;
    localparam int          STAB_W        = 18;
    localparam logic [1:0]  ARM_DONE      = 2'h3;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RUN  = 4'b0001,
        ST_STOP = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_STAB = 4'b1000
    } smws_state_e;

endpackage

// ==== design/smws_sync.sv ====
// Purpose : Two flip-flop synchroniser for pin inputs
// Assumes : Inputs are asynchronous levels
// Notes   : Only the second stage is visible outside
`timescale 1ns/10ps
`default_nettype none
module smws_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_in,
    input  wire logic         nrst_in,
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);
    logic [W-1:0] meta_reg;

    // ------------------------------------------------------------
    // Two stage capture
    // ------------------------------------------------------------
    // First stage feeds only the second stage
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            meta_reg <= '0;
            q_out    <= '0;
        end else begin
            meta_reg <= d_in;
            q_out    <= meta_reg;
        end
    end
endmodule // smws_sync
`default_nettype wire

// ==== dv/smws_core_model.sv ====
// Purpose : Core and interrupt source facing the stop sequencer
// Assumes : Interrupt pin idles at its inactive level
// Notes   : Acknowledge lag is set from the bench
`timescale 1ns/10ps
`default_nettype none
module smws_core_model (
    input  wire logic sys_clk_in,
    input  wire logic nmi_rise_sel_in,
    input  wire logic nmi_take_in,
    output wire logic nmi_pin_out,
    output wire logic nmi_ack_out
);
    // ----------
    // Pin and acknowledge
    // ----------
    logic       active_reg = 1'b0;
    logic [3:0] take_reg   = 4'h0;
    int         ack_lag    = 0;

    // Idle level is the opposite of where a valid edge goes
    assign nmi_pin_out = active_reg ? nmi_rise_sel_in : ~nmi_rise_sel_in;

    // Core acks a taken branch late; lag 0 is prompt
    always @(posedge sys_clk_in) begin
        take_reg <= {take_reg[2:0], nmi_take_in};
    end
    assign nmi_ack_out = take_reg[ack_lag];

    // Level changes only just after an edge
    task automatic drive(input logic a);
        @(posedge sys_clk_in);
        active_reg <= a;
    endtask
endmodule // smws_core_model
`default_nettype wire

// ==== dv/smws_bench.sv ====
// Purpose : Self-checking bench for the stop mode wake sequencer
// Assumes : Stabilization counts shortened to 16 and 32 cycles
// Notes   : Interrupt source and core ack come from the core model
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module stop_mode_wake_sequencer_bench;
    import smws_pkg::*;
    localparam int unsigned C256 = 16;
    localparam int unsigned C512 = 32;
    // ----------
    // Signals
    // ----------
    logic       sys_clk_in, nrst_in, psc_wr_in, nmi_rise_sel_in;
    logic       nmi_pending_flag_in, single_chip_in, flash_prog_in;
    logic [7:0] psc_wdata_in;
    wire logic  nmi_pin_in, nmi_ack_in, cpu_clk_en_out, sys_clk_en_out;
    wire logic  clkgen_en_out, periph_stop_out, bus_float_out, port_hold_out;
    wire logic  stop_mode_out, stab_busy_out, nmi_req_out, nmi_take_out;
    wire logic  clock_output_pin_out;
    wire logic [7:0] psc_rdata_out;
    int         error_cnt = 0;
    int         check_count = 0;
    int         seed = 59694;
    int         n_busy = 0;
    int         n_take = 0;
    bit [2:0]   tab [5] = '{3'b000, 3'b010, 3'b100, 3'b001, 3'b101};

    smws_top #(.STAB_CYC_DIV256(C256), .STAB_CYC_DIV512(C512)) uut (
        .sys_clk_in, .nrst_in, .psc_wr_in, .psc_wdata_in, .nmi_pin_in,
        .nmi_rise_sel_in, .nmi_ack_in, .nmi_pending_flag_in, .single_chip_in,
        .flash_prog_in, .psc_rdata_out, .cpu_clk_en_out, .sys_clk_en_out,
        .clkgen_en_out, .periph_stop_out, .bus_float_out, .port_hold_out,
        .stop_mode_out, .stab_busy_out, .nmi_req_out, .nmi_take_out,
        .clock_output_pin_out);

    smws_core_model core (.sys_clk_in, .nmi_rise_sel_in, .nmi_take_in(nmi_take_out),
        .nmi_pin_out(nmi_pin_in), .nmi_ack_out(nmi_ack_in));

    // 25 MHz oscillator clock
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    // Reference model: busy cycles and branch pulses since last clear
    always @(negedge sys_clk_in) begin
        if (stab_busy_out === 1'b1) n_busy++;
        if (nmi_take_out === 1'b1) n_take++;
    end

    // ----------
    // Tasks
    // ----------
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Polarity only moves inside reset, so no false edge is seen
    task automatic rst(input int n, input logic rise);
        @(posedge sys_clk_in);
        nrst_in <= 1'b0;
        nmi_rise_sel_in <= rise;
        repeat (n) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        repeat (5) @(posedge sys_clk_in);
    endtask

    task automatic wr(input logic [7:0] d);
        @(posedge sys_clk_in);
        psc_wr_in <= 1'b1;
        psc_wdata_in <= d;
        @(posedge sys_clk_in);
        psc_wr_in <= 1'b0;
    endtask

    task automatic wait_run();
        int i;
        for (i = 0; i < 300; i++) begin
            @(negedge sys_clk_in);
            if (cpu_clk_en_out === 1'b1) break;
        end
        if (i == 300) begin
            error_cnt++;
            $display("[ERR] %0t wake timed out", $time);
            complete_run();
        end
    endtask

    task automatic count_tog(output int t);
        logic last;
        t = 0;
        repeat (2) @(negedge sys_clk_in);
        last = clock_output_pin_out;
        repeat (12) begin
            @(negedge sys_clk_in);
            if (clock_output_pin_out !== last) t++;
            last = clock_output_pin_out;
        end
    endtask

    // Enter stop with clock output enabled, then wake by the pin
    task automatic nmi_wake(input bit ce, input bit tb, input bit pend);
        int w;
        w = 6 + $unsigned($random(seed)) % 4;
        @(posedge sys_clk_in);
        nmi_pending_flag_in <= pend;
        wr({2'h0, tb, ce, 4'h2});
        @(negedge sys_clk_in);
        `CHK(stop_mode_out, 1'b1)
        `CHK({cpu_clk_en_out, sys_clk_en_out, clkgen_en_out}, 3'h0)
        `CHK({periph_stop_out, bus_float_out, port_hold_out, clock_output_pin_out}, 4'he)
        `CHK(psc_rdata_out[STOP_BIT], 1'b1)
        wr(8'h00);
        repeat (3) @(negedge sys_clk_in);
        `CHK(stop_mode_out, 1'b1)
        n_busy = 0;
        n_take = 0;
        core.drive(1'b1);
        repeat (w) @(negedge sys_clk_in);
        `CHK({stop_mode_out, cpu_clk_en_out, clkgen_en_out}, ce ? 3'h3 : 3'h5)
        `CHK(n_busy, 0)
        core.drive(1'b0);
        wait_run();
        repeat (5) @(negedge sys_clk_in);
        `CHK(n_busy, ce ? 0 : (tb ? C512 : C256))
        `CHK(n_take, pend ? 0 : 1)
        `CHK(nmi_req_out, pend)
    endtask

    // Stop asked while a request still waits for its ack
    task automatic stop_pending(input bit ce);
        n_busy = 0;
        @(posedge sys_clk_in);
        nmi_pending_flag_in <= 1'b0;
        wr({3'h0, ~ce, 4'h0});
        wr({3'h0, ce, 4'h2});
        @(negedge sys_clk_in);
        `CHK(stop_mode_out, ~ce)
        wait_run();
        repeat (2) @(negedge sys_clk_in);
        `CHK(n_busy, ce ? 0 : C256)
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge sys_clk_in);
        error_cnt++;
        $display("[ERR] %0t run limit reached", $time);
        complete_run();
    end

    // ----------
    // Main sequence
    // ----------
    initial begin
        int t;
        logic [7:0] d;
        nrst_in = 1'b0;
        psc_wr_in = 1'b0;
        psc_wdata_in = 8'h00;
        nmi_rise_sel_in = 1'b1;
        nmi_pending_flag_in = 1'b0;
        single_chip_in = 1'b1;
        flash_prog_in = 1'b0;
        repeat (20) @(posedge sys_clk_in);
        rst(1, 1'b1);
        @(negedge sys_clk_in);
        `CHK(psc_rdata_out, PSC_RESET)
        `CHK({cpu_clk_en_out, clkgen_en_out, stop_mode_out}, 3'h6)
        count_tog(t);
        `CHK(t, 0)
        // Every mode code, ending on normal output
        for (int m = 1; m <= 4; m++) begin
            d = {m[1:0], 2'($random(seed)), 4'h0};
            wr(d);
            count_tog(t);
            `CHK(psc_rdata_out, d)
            `CHK(t, (d[7:6] == CLOCK_OUTPUT_PIN_NORMAL) ? 12 : 0)
        end
        @(posedge sys_clk_in);
        flash_prog_in <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        count_tog(t);
        `CHK(t, 0)
        @(posedge sys_clk_in);
        flash_prog_in <= 1'b0;
        $display("clock output test done");
        for (int i = 0; i < 5; i++) begin
            rst(3, i[0]);
            core.ack_lag = $unsigned($random(seed)) % 3;
            wr(8'h00);
            nmi_wake(tab[i][2], tab[i][1], tab[i][0]);
            if (tab[i][0]) stop_pending(tab[i][2]);
            $display("interrupt wake case %0d done", i);
        end
        wr(8'h02);
        repeat (3) @(posedge sys_clk_in);
        rst(3 + $unsigned($random(seed)) % 6, 1'b1);
        @(negedge sys_clk_in);
        `CHK({stop_mode_out, cpu_clk_en_out, clkgen_en_out}, 3'h3)
        `CHK(psc_rdata_out, PSC_RESET)
        $display("reset wake test done");
        complete_run();
    end
endmodule // stop_mode_wake_sequencer_bench
`default_nettype wire
